// file: pms_target.sv
`include "pms_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module pms_target #(
  parameter int TIMEOUT_CYC = `PMS_TIMEOUT_CYC,
  parameter int IDLE_CYC = `PMS_IDLE_CYC,
  parameter int STRETCH_CYC = `PMS_STRETCH_CYC
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rstn_i,
  // Bus pins; an enable low means the pin is pulled low.
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_oen_o,
  input wire logic serial_data_pin_i,
  output logic serial_data_pin_oen_o,
  output logic alert_n_o,
  input wire logic bus_control_pin_i,
  // Configuration.
  input wire logic [6:0] own_addr_i,
  input wire logic bus_idle_reset_inhibit_i,
  // Device side.
  input wire pms_pkg::pms_health_t health_i,
  input wire logic fault_i,
  input wire logic [7:0] fault_code_i,
  input wire logic nvm_busy_i,
  output pms_pkg::pms_nvm_req_t nvm_req_o,
  output logic [7:0] operation_o,
  output logic power_on_o,
  output logic timeout_o
);
  logic scl, sda, scl_d, sda_d;
  pms_pkg::pms_state_t state;
  logic [7:0] sh;
  logic [3:0] bitcnt;
  logic rw, ara, first;
  logic [7:0] cmd;
  logic [2:0] rdidx;
  logic [31:0] lowcnt, idlecnt, strcnt, stamp;
  logic fault_pend;
  logic [7:0] last_fault;
  logic abort;
  logic [7:0] rdbyte;
  logic ctl_low;

  pms_sync u_scl (.clk_i(clk_i), .rstn_i(rstn_i), .d_i(serial_clock_pin_i), .q_o(scl));
  pms_sync u_sda (.clk_i(clk_i), .rstn_i(rstn_i), .d_i(serial_data_pin_i), .q_o(sda));
  // The control pin is synchronised inverted, so the synchroniser's high reset reads as released.
  pms_sync u_ctl (.clk_i(clk_i), .rstn_i(rstn_i), .d_i(!bus_control_pin_i), .q_o(ctl_low));

  wire scl_rise = scl & ~scl_d;
  wire scl_fall = ~scl & scl_d;
  wire start_c = scl & scl_d & sda_d & ~sda;
  wire stop_c = scl & scl_d & ~sda_d & sda;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl;
      sda_d <= sda;
    end
  end

  // Clock-low and idle-high watchdogs.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lowcnt <= 32'h0;
      idlecnt <= 32'h0;
    end else begin
      lowcnt <= scl ? 32'h0 : lowcnt + 32'h1;
      idlecnt <= (scl && sda) ? idlecnt + 32'h1 : 32'h0;
    end
  end

  wire low_to = (lowcnt >= 32'(TIMEOUT_CYC));
  // The idle reset needs both lines still high, so a start after a long idle is not lost.
  wire idle_to = !bus_idle_reset_inhibit_i && scl && sda && (idlecnt >= 32'(IDLE_CYC));
  assign abort = low_to || idle_to;

  // Stretching budget over a message; stretch is only while NVM is busy.
  wire want_stretch = nvm_busy_i && (state == pms_pkg::PMS_WRITE) && !scl;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      strcnt <= 32'h0;
    end else if (start_c) begin
      strcnt <= 32'h0;
    end else if (!serial_clock_pin_oen_o) begin
      strcnt <= strcnt + 32'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      serial_clock_pin_oen_o <= 1'b1;
    end else begin
      // Stretching ends before the budget, leaving host-side margin.
      serial_clock_pin_oen_o <= !(want_stretch && !abort &&
                                  (strcnt + 32'h2 < 32'(STRETCH_CYC)));
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      timeout_o <= 1'b0;
    end else begin
      timeout_o <= low_to;
    end
  end

  // Read data selection.
  always_comb begin
    rdbyte = 8'h00;
    if (ara) begin
      rdbyte = {own_addr_i, 1'b1};
    end else begin
      unique case (cmd)
        `PMS_CMD_OPERATION: rdbyte = operation_o;
        `PMS_CMD_STATUS_BYTE: rdbyte = health_i.status;
        `PMS_CMD_READ_VOUT: rdbyte = rdidx[0] ? health_i.vout[15:8] : health_i.vout[7:0];
        `PMS_CMD_READ_IOUT: rdbyte = rdidx[0] ? health_i.iout[15:8] : health_i.iout[7:0];
        `PMS_CMD_READ_TEMP: rdbyte = rdidx[0] ? health_i.temp[15:8] : health_i.temp[7:0];
        `PMS_CMD_MFR_FAULT_LOG: rdbyte = last_fault;
        default: rdbyte = 8'hFF;
      endcase
    end
  end

  // Byte engine.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= pms_pkg::PMS_IDLE;
      sh <= 8'h00;
      bitcnt <= 4'h0;
      rw <= 1'b0;
      ara <= 1'b0;
      first <= 1'b0;
      cmd <= 8'h00;
      rdidx <= 3'h0;
      serial_data_pin_oen_o <= 1'b1;
    end else if (abort) begin
      state <= pms_pkg::PMS_IDLE;
      serial_data_pin_oen_o <= 1'b1;
    end else if (start_c) begin
      state <= pms_pkg::PMS_ADDR;
      bitcnt <= 4'h0;
      serial_data_pin_oen_o <= 1'b1;
    end else if (stop_c) begin
      state <= pms_pkg::PMS_IDLE;
      serial_data_pin_oen_o <= 1'b1;
    end else begin
      unique case (state)
        pms_pkg::PMS_IDLE, pms_pkg::PMS_IGNORE: serial_data_pin_oen_o <= 1'b1;
        pms_pkg::PMS_ADDR, pms_pkg::PMS_WRITE: begin
          if (scl_rise) begin
            sh <= {sh[6:0], sda};
            bitcnt <= bitcnt + 4'h1;
          end
          if (scl_fall && bitcnt == 4'h8) begin
            bitcnt <= 4'h0;
            if (state == pms_pkg::PMS_ADDR) begin
              if (sh[7:1] == own_addr_i || (sh[7:1] == `PMS_ARA_ADDR && fault_pend)) begin
                serial_data_pin_oen_o <= 1'b0;
                rw <= sh[0];
                ara <= (sh[7:1] == `PMS_ARA_ADDR);
                first <= 1'b1;
                rdidx <= 3'h0;
                state <= pms_pkg::PMS_ACK;
              end else begin
                state <= pms_pkg::PMS_IGNORE;
              end
            end else begin
              serial_data_pin_oen_o <= 1'b0;
              if (first) begin
                cmd <= sh;
              end
              first <= 1'b0;
              state <= pms_pkg::PMS_ACK;
            end
          end
        end
        pms_pkg::PMS_ACK: begin
          if (scl_fall) begin
            if (rw) begin
              serial_data_pin_oen_o <= rdbyte[7];
              sh <= {rdbyte[6:0], 1'b0};
              bitcnt <= 4'h1;
              state <= pms_pkg::PMS_READ;
            end else begin
              serial_data_pin_oen_o <= 1'b1;
              state <= pms_pkg::PMS_WRITE;
            end
          end
        end
        pms_pkg::PMS_READ: begin
          if (scl_fall) begin
            if (bitcnt == 4'h8) begin
              serial_data_pin_oen_o <= 1'b1;
              rdidx <= rdidx + 3'h1;
              state <= pms_pkg::PMS_RACK;
            end else begin
              serial_data_pin_oen_o <= sh[7];
              sh <= {sh[6:0], 1'b0};
              bitcnt <= bitcnt + 4'h1;
            end
          end
        end
        pms_pkg::PMS_RACK: begin
          if (scl_rise) begin
            state <= sda ? pms_pkg::PMS_IGNORE : pms_pkg::PMS_ACK;
          end
        end
        default: state <= pms_pkg::PMS_IDLE;
      endcase
    end
  end

  // Write effects: operation command, store, clear faults.
  wire wr_done = (state == pms_pkg::PMS_WRITE) && scl_fall && bitcnt == 4'h8 && !abort;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      operation_o <= 8'h00;
      nvm_req_o <= '0;
      stamp <= 32'h0;
    end else begin
      stamp <= stamp + 32'h1;
      nvm_req_o.store_cfg <= wr_done && first && sh == `PMS_CMD_STORE_DEFAULT;
      nvm_req_o.log_fault <= fault_i;
      nvm_req_o.fault_code <= fault_code_i;
      nvm_req_o.stamp <= stamp;
      if (wr_done && !first && cmd == `PMS_CMD_OPERATION) begin
        operation_o <= sh;
      end
    end
  end

  // Power-up request from pin or operation bit 7.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      power_on_o <= 1'b0;
    end else begin
      power_on_o <= !ctl_low | operation_o[7];
    end
  end

  // Alert: fault sets, clear-faults or alert response clears; set wins.
  wire ara_done = ara && (state == pms_pkg::PMS_RACK) && scl_rise;
  wire clr_cmd = wr_done && first && sh == `PMS_CMD_CLEAR_FAULTS;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fault_pend <= 1'b0;
      last_fault <= 8'h00;
      alert_n_o <= 1'b1;
    end else begin
      if (fault_i) begin
        fault_pend <= 1'b1;
        last_fault <= fault_code_i;
      end else if (clr_cmd || ara_done) begin
        fault_pend <= 1'b0;
      end
      alert_n_o <= !fault_pend;
    end
  end

  timeout_abort_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    low_to |=> state == pms_pkg::PMS_IDLE && serial_data_pin_oen_o)
    else $error("Clock-low timeout did not release the bus.");

  idle_reset_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (!bus_idle_reset_inhibit_i && scl && sda && idlecnt >= 32'(IDLE_CYC)) |=>
      state == pms_pkg::PMS_IDLE)
    else $error("Idle bus did not reset the transfer.");

  stretch_budget_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !serial_clock_pin_oen_o |-> strcnt < 32'(STRETCH_CYC))
    else $error("Clock stretch exceeded the budget.");

  alert_follow_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    fault_i |=> ##1 !alert_n_o)
    else $error("Fault did not raise the alert.");

  foreign_addr_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state == pms_pkg::PMS_IGNORE |-> serial_data_pin_oen_o)
    else $error("Data driven for a foreign address.");

  store_cmd_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (wr_done && first && sh == `PMS_CMD_STORE_DEFAULT) |=> nvm_req_o.store_cfg)
    else $error("Store command not passed to memory.");

  fault_log_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    fault_i |=> nvm_req_o.log_fault && nvm_req_o.fault_code == $past(fault_code_i))
    else $error("Fault not logged.");

  power_req_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    bus_control_pin_i |=> ##2 power_on_o)
    else $error("Control pin did not request power-up.");
endmodule
`default_nettype wire

// file: pms_defines.svh
`ifndef PMS_DEFINES_SVH
`define PMS_DEFINES_SVH

// Clock rate in kHz and bus timing figures.
`define PMS_CLK_KHZ 50000
`define PMS_TIMEOUT_MS 35
`define PMS_IDLE_MS 50
`define PMS_STRETCH_MS 25
`define PMS_TIMEOUT_CYC (`PMS_TIMEOUT_MS * `PMS_CLK_KHZ)
`define PMS_IDLE_CYC (`PMS_IDLE_MS * `PMS_CLK_KHZ)
`define PMS_STRETCH_CYC (`PMS_STRETCH_MS * `PMS_CLK_KHZ)

// Command codes handled by the target, and the alert response address.
`define PMS_CMD_OPERATION 8'h01
`define PMS_CMD_CLEAR_FAULTS 8'h03
`define PMS_CMD_STORE_DEFAULT 8'h11
`define PMS_CMD_STATUS_BYTE 8'h78
`define PMS_CMD_READ_VOUT 8'h8B
`define PMS_CMD_READ_IOUT 8'h8C
`define PMS_CMD_READ_TEMP 8'h8D
`define PMS_CMD_MFR_FAULT_LOG 8'hEA
`define PMS_ARA_ADDR 7'h0C

`endif

// file: pms_pkg.sv
package pms_pkg;
  typedef enum logic [2:0] {
    PMS_IDLE, PMS_ADDR, PMS_ACK, PMS_WRITE, PMS_READ, PMS_RACK, PMS_IGNORE
  } pms_state_t;

  // Health data offered by the monitor logic.
  typedef struct packed {
    logic [15:0] vout;
    logic [15:0] iout;
    logic [15:0] temp;
    logic [7:0] status;
  } pms_health_t;

  // Request to the nonvolatile store.
  typedef struct packed {
    logic store_cfg;
    logic log_fault;
    logic [7:0] fault_code;
    logic [31:0] stamp;
  } pms_nvm_req_t;
endpackage

// file: pms_sync.sv
`timescale 1ns/100ps
`default_nettype none
module pms_sync (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta <= 1'b1;
      q_o <= 1'b1;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule
`default_nettype wire

// file: pms_host.sv
`timescale 1ns/100ps
`default_nettype none
module pms_host (
  // Clock.
  input wire logic clk_i,
  // Bus levels and open-drain enables; an enable low pulls the line low.
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_oen_o,
  output logic sda_oen_o
);
  // Half a bus clock period in system cycles; 4 gives the 160 ns link period.
  int half = 4;
  initial begin
    scl_oen_o = 1'b1;
    sda_oen_o = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // A stretched clock is waited out under a bound, so a stuck target cannot hang the host.
  task automatic rise();
    int n;
    n = 0;
    scl_oen_o <= 1'b1;
    tick(1);
    while (scl_i !== 1'b1 && n < 5000) begin
      tick(1);
      n++;
    end
  endtask
  task automatic start();
    sda_oen_o <= 1'b1;
    tick(half);
    rise();
    tick(half);
    sda_oen_o <= 1'b0;
    tick(half);
    scl_oen_o <= 1'b0;
    tick(half);
  endtask
  task automatic stop();
    sda_oen_o <= 1'b0;
    tick(half);
    rise();
    tick(half);
    sda_oen_o <= 1'b1;
    tick(half);
  endtask
  // Data moves one cycle after the clock falls, so the target never sees it race the edge.
  task automatic bit_io(input logic b, output logic r);
    sda_oen_o <= b;
    tick(half - 1);
    rise();
    tick(half / 2 - 1);
    r = sda_i;
    tick(half - half / 2);
    scl_oen_o <= 1'b0;
    tick(1);
  endtask
  // Most significant bit first; the ninth bit carries the acknowledge.
  task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q,
                      output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], b);
      q[i] = b;
    end
    bit_io(ai, ack);
  endtask
endmodule
`default_nettype wire

// file: pms_target_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "pms_defines.svh"
module pms_target_tb;
  localparam int TMO = 2000;
  localparam int IDL = 3000;
  localparam int STR = 1500;
  localparam logic [6:0] ADDR = 7'h5A;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic scl_doen, sda_doen, scl_hoen, sda_hoen, alert_n, power_on, timeout;
  logic bus_ctl = 1'b0;
  logic fault = 1'b0;
  logic nvm_busy = 1'b0;
  logic [7:0] fault_code = 8'h00;
  logic [7:0] operation;
  logic [6:0] own_addr = ADDR;
  logic idle_inhibit = 1'b0;
  int store_cnt = 0;
  int log_cnt = 0;
  logic [7:0] log_code = 8'h00;
  logic [31:0] log_stamp = 32'h0;
  pms_pkg::pms_health_t health = '{16'h1234, 16'hABCD, 16'h0F3C, 8'h42};
  pms_pkg::pms_nvm_req_t nvm_req;
  int errors = 0;
  int comparisons = 0;
  int stretch_cnt = 0;
  wire scl_w;
  wire sda_w;
  assign scl_w = scl_doen & scl_hoen;
  assign sda_w = sda_doen & sda_hoen;
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (scl_doen === 1'b0)
      stretch_cnt <= stretch_cnt + 1;
    if (nvm_req.store_cfg === 1'b1)
      store_cnt <= store_cnt + 1;
    if (nvm_req.log_fault === 1'b1) begin
      log_cnt <= log_cnt + 1;
      log_code <= nvm_req.fault_code;
      log_stamp <= nvm_req.stamp;
    end
  end
  pms_target #(.TIMEOUT_CYC(TMO), .IDLE_CYC(IDL), .STRETCH_CYC(STR)) i_dut (
    .clk_i(clk_i), .rstn_i(rstn_i),
    .serial_clock_pin_i(scl_w), .serial_clock_pin_oen_o(scl_doen),
    .serial_data_pin_i(sda_w), .serial_data_pin_oen_o(sda_doen),
    .alert_n_o(alert_n), .bus_control_pin_i(bus_ctl),
    .own_addr_i(own_addr), .bus_idle_reset_inhibit_i(idle_inhibit),
    .health_i(health), .fault_i(fault), .fault_code_i(fault_code),
    .nvm_busy_i(nvm_busy), .nvm_req_o(nvm_req), .operation_o(operation),
    .power_on_o(power_on), .timeout_o(timeout)
  );
  pms_host i_host (
    .clk_i(clk_i), .scl_i(scl_w), .sda_i(sda_w), .scl_oen_o(scl_hoen), .sda_oen_o(sda_hoen)
  );
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("Comparisons %0d mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d,
                    input bit wd, output logic [2:0] k);
    logic [7:0] q;
    k = 3'b000;
    i_host.start();
    i_host.xfer({a, 1'b0}, 1'b1, q, k[2]);
    i_host.xfer(c, 1'b1, q, k[1]);
    if (wd)
      i_host.xfer(d, 1'b1, q, k[0]);
    i_host.stop();
  endtask
  task automatic rd(input logic [7:0] c, input int n, output logic [15:0] v);
    logic [7:0] q;
    logic k;
    i_host.start();
    i_host.xfer({ADDR, 1'b0}, 1'b1, q, k);
    i_host.xfer(c, 1'b1, q, k);
    i_host.start();
    i_host.xfer({ADDR, 1'b1}, 1'b1, q, k);
    i_host.xfer(8'hFF, n == 1, q, k);
    v = {8'h00, q};
    if (n == 2) begin
      i_host.xfer(8'hFF, 1'b1, q, k);
      v[15:8] = q;
    end
    i_host.stop();
  endtask
  task automatic ara(output logic [7:0] q, output logic k);
    logic k2;
    i_host.start();
    i_host.xfer({`PMS_ARA_ADDR, 1'b1}, 1'b1, q, k);
    if (k === 1'b0)
      i_host.xfer(8'hFF, 1'b1, q, k2);
    i_host.stop();
  endtask
  // Long high gap inside a write; a surviving transfer would take the next bits as data.
  task automatic idle_gap(output logic k);
    logic [7:0] q;
    i_host.start();
    i_host.xfer({ADDR, 1'b0}, 1'b1, q, k);
    i_host.xfer(`PMS_CMD_OPERATION, 1'b1, q, k);
    i_host.tick(4);
    i_host.rise();
    i_host.tick(IDL + 20);
    i_host.scl_oen_o <= 1'b0;
    i_host.tick(1);
    i_host.xfer(8'h00, 1'b1, q, k);
    i_host.stop();
  endtask
  task automatic t_reset();
    check("scl oen", scl_doen, 1);
    check("sda oen", sda_doen, 1);
    check("alert", alert_n, 1);
    check("timeout", timeout, 0);
    $display("test reset done");
  endtask
  task automatic t_addr();
    logic [2:0] k;
    wr(ADDR ^ 7'h01, `PMS_CMD_OPERATION, 8'h80, 1, k);
    check("foreign acks", k, 3'b111);
    check("operation kept", operation, 8'h00);
    wr(ADDR, `PMS_CMD_OPERATION, 8'h80, 1, k);
    check("own acks", k, 3'b000);
    check("operation", operation, 8'h80);
    i_host.tick(2);
    check("power on by command", power_on, 1);
    wr(ADDR, `PMS_CMD_OPERATION, 8'h00, 1, k);
    i_host.tick(2);
    check("power off", power_on, 0);
    bus_ctl <= 1'b1;
    i_host.tick(5);
    check("power on by pin", power_on, 1);
    bus_ctl <= 1'b0;
    own_addr <= ADDR ^ 7'h01;
    wr(ADDR ^ 7'h01, `PMS_CMD_STATUS_BYTE, 8'h00, 0, k);
    check("moved address acks", k, 3'b000);
    own_addr <= ADDR;
    $display("test address done");
  endtask
  task automatic t_health();
    logic [15:0] v;
    rd(`PMS_CMD_READ_VOUT, 2, v);
    check("vout", v, health.vout);
    rd(`PMS_CMD_READ_IOUT, 2, v);
    check("iout", v, health.iout);
    rd(`PMS_CMD_READ_TEMP, 2, v);
    check("temp", v, health.temp);
    rd(`PMS_CMD_STATUS_BYTE, 1, v);
    check("status", v, {8'h00, health.status});
    i_host.half = 10;
    health.vout <= 16'h5AA5;
    rd(`PMS_CMD_READ_VOUT, 2, v);
    check("vout slow bus", v, health.vout);
    i_host.half = 4;
    $display("test health done");
  endtask
  task automatic t_fault();
    logic [15:0] v;
    logic [7:0] q;
    logic k;
    logic [2:0] kw;
    logic [31:0] s1;
    int l0;
    l0 = log_cnt;
    fault_code <= 8'hA5;
    fault <= 1'b1;
    i_host.tick(1);
    fault <= 1'b0;
    i_host.tick(4);
    s1 = log_stamp;
    check("log pulse", log_cnt - l0, 1);
    check("log code", log_code, 8'hA5);
    check("alert set", alert_n, 0);
    rd(`PMS_CMD_MFR_FAULT_LOG, 1, v);
    check("log read", v, 16'h00A5);
    ara(q, k);
    check("ara ack", k, 0);
    check("ara addr", q[7:1], ADDR);
    i_host.tick(4);
    check("alert cleared by ara", alert_n, 1);
    ara(q, k);
    check("ara idle nack", k, 1);
    fault <= 1'b1;
    i_host.tick(1);
    fault <= 1'b0;
    i_host.tick(4);
    check("stamp advances", log_stamp > s1, 1);
    check("alert set again", alert_n, 0);
    wr(ADDR, `PMS_CMD_CLEAR_FAULTS, 8'h00, 0, kw);
    check("alert cleared by command", alert_n, 1);
    $display("test fault done");
  endtask
  task automatic t_store();
    logic [2:0] k;
    int s0;
    int n0;
    s0 = stretch_cnt;
    n0 = store_cnt;
    nvm_busy <= 1'b1;
    i_host.tick(1);
    wr(ADDR, `PMS_CMD_STORE_DEFAULT, 8'h00, 0, k);
    check("store acks", k, 3'b000);
    check("stretched", stretch_cnt - s0 > 0, 1);
    check("stretch budget", stretch_cnt - s0 <= STR, 1);
    nvm_busy <= 1'b0;
    i_host.tick(10);
    check("store request", store_cnt - n0, 1);
    $display("test store done");
  endtask
  task automatic t_bus_limits();
    logic [7:0] q;
    logic k;
    logic [15:0] v;
    logic [2:0] kw;
    i_host.start();
    i_host.xfer({ADDR, 1'b0}, 1'b1, q, k);
    i_host.tick(TMO + 20);
    check("timeout flag", timeout, 1);
    check("sda released", sda_doen, 1);
    i_host.stop();
    check("timeout cleared", timeout, 0);
    idle_gap(k);
    check("idle reset nack", k, 1);
    check("idle drops byte", operation, 8'h00);
    idle_inhibit <= 1'b1;
    idle_gap(k);
    check("inhibit keeps byte", operation, 8'h80);
    idle_inhibit <= 1'b0;
    wr(ADDR, `PMS_CMD_OPERATION, 8'h00, 1, kw);
    check("operation cleared", operation, 8'h00);
    rd(`PMS_CMD_READ_VOUT, 2, v);
    check("recovered", v, health.vout);
    $display("test bus limits done");
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    i_host.tick(5);
    t_reset();
    t_addr();
    t_health();
    t_fault();
    t_store();
    t_bus_limits();
    tally_and_finish();
  end
  initial begin
    repeat (60000) @(posedge clk_i);
    errors++;
    $display("[ERR] watchdog expected done seen hang");
    tally_and_finish();
  end
endmodule
`default_nettype wire
